// file: verilog/bsrs_supervisor.sv
`timescale 1ns/1ns
module bsrs_supervisor #(
  parameter int unsigned POR_CYCLES = bsrs_pkg::POR_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  // Comparator results
  input  wire bsrs_pkg::bsrs_sense_type sense_in,
  // Open-drain outputs
  output bsrs_pkg::bsrs_od_pin_type     sys_reset_n,
  output bsrs_pkg::bsrs_od_pin_type     power_off_n,
  output bsrs_pkg::bsrs_od_pin_type     low_batt_warn_n
);

  localparam int unsigned W = bsrs_pkg::CNT_W;
  localparam logic [W-1:0] POR_LAST  = W'(POR_CYCLES - 1);
  localparam logic [W-1:0] MAN_LAST  = W'(POR_CYCLES / bsrs_pkg::MAN_DIV - 1);
  localparam logic [W-1:0] DBNC_LAST = W'(POR_CYCLES / bsrs_pkg::DBNC_DIV - 1);
  localparam logic [bsrs_pkg::FILT_W-1:0] FILT_LAST =
    bsrs_pkg::FILT_W'(bsrs_pkg::GLITCH_CYCLES - 1);

  logic [bsrs_pkg::NSENSE-1:0] sync1_q;
  logic [bsrs_pkg::NSENSE-1:0] sync2_q;
  logic [bsrs_pkg::NSENSE-1:0] filt_q;
  bsrs_pkg::bsrs_sense_type    sense_f;
  bsrs_pkg::bsrs_state_type    state_q;
  bsrs_pkg::bsrs_state_type    state_d;
  logic [W-1:0]                cnt_q;
  logic                        rst_oe_q;
  logic                        pof_oe_q;
  logic                        warn_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // Input conditioning

  // Two-flop synchronisers; only the second stage feeds the filters
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= bsrs_pkg::SENSE_RST;
      sync2_q <= bsrs_pkg::SENSE_RST;
    end else begin
      sync1_q <= sense_in;
      sync2_q <= sync1_q;
    end
  end

  // Glitch filter: a level must persist a full window before it is believed
  genvar gi;
  generate
    for (gi = 0; gi < bsrs_pkg::NSENSE; gi++) begin : g_filt
      logic [bsrs_pkg::FILT_W-1:0] fcnt_q;
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          fcnt_q      <= '0;
          filt_q[gi]  <= bsrs_pkg::SENSE_RST[gi];
        end else if (sync2_q[gi] == filt_q[gi]) begin
          fcnt_q <= '0;
        end else if (fcnt_q == FILT_LAST) begin
          fcnt_q     <= '0;
          filt_q[gi] <= sync2_q[gi];
        end else begin
          fcnt_q <= fcnt_q + 1'b1;
        end
      end
    end
  endgenerate

  assign sense_f = bsrs_pkg::bsrs_sense_type'(filt_q);

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state; the dead-battery check outranks everything once powered
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bsrs_pkg::ST_WAIT_POR: begin
        if (sense_f.fresh_above) state_d = bsrs_pkg::ST_POR;
      end
      bsrs_pkg::ST_POR: begin
        // Manual requests are not looked at while the pulse runs
        if (!sense_f.dead_above) state_d = bsrs_pkg::ST_DEAD;
        else if (cnt_q == POR_LAST) state_d = bsrs_pkg::ST_RUN;
      end
      bsrs_pkg::ST_RUN: begin
        // Fresh level is ignored here; only dead and manual matter
        if (!sense_f.dead_above) state_d = bsrs_pkg::ST_DEAD;
        else if (sense_f.manual_below) state_d = bsrs_pkg::ST_DBNC;
      end
      bsrs_pkg::ST_DBNC: begin
        if (!sense_f.dead_above) state_d = bsrs_pkg::ST_DEAD;
        else if (!sense_f.manual_below) state_d = bsrs_pkg::ST_RUN;
        else if (cnt_q == DBNC_LAST) state_d = bsrs_pkg::ST_MAN;
      end
      bsrs_pkg::ST_MAN: begin
        if (!sense_f.dead_above) state_d = bsrs_pkg::ST_DEAD;
        else if (cnt_q == MAN_LAST) state_d = bsrs_pkg::ST_HOLD;
      end
      bsrs_pkg::ST_HOLD: begin
        // Held switch waits here so the pulse is neither stretched nor repeated
        if (!sense_f.dead_above) state_d = bsrs_pkg::ST_DEAD;
        else if (!sense_f.manual_below) state_d = bsrs_pkg::ST_RUN;
      end
      bsrs_pkg::ST_DEAD: begin
        // Need the fresh input low first so a stale high is not a new event
        if (!sense_f.fresh_above) state_d = bsrs_pkg::ST_DEAD_ARM;
      end
      bsrs_pkg::ST_DEAD_ARM: begin
        if (sense_f.fresh_above) state_d = bsrs_pkg::ST_POR;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) state_q <= bsrs_pkg::ST_WAIT_POR;
    else         state_q <= state_d;
  end

  // One shared counter times debounce, manual and power-on intervals
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)               cnt_q <= '0;
    else if (state_d != state_q) cnt_q <= '0;
    else                       cnt_q <= cnt_q + 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Reset and power-off pull-downs registered from the next state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_oe_q <= 1'b1;
      pof_oe_q <= 1'b0;
    end else begin
      rst_oe_q <= state_d inside {bsrs_pkg::ST_WAIT_POR, bsrs_pkg::ST_POR,
                                  bsrs_pkg::ST_MAN, bsrs_pkg::ST_DEAD,
                                  bsrs_pkg::ST_DEAD_ARM};
      pof_oe_q <= state_d inside {bsrs_pkg::ST_DEAD,
                                  bsrs_pkg::ST_DEAD_ARM};
    end
  end

  // Warning follows its own comparator and touches nothing else
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) warn_oe_q <= 1'b0;
    else         warn_oe_q <= !sense_f.low_above;
  end

  // Pins only ever pull low; the pull-up is outside
  assign sys_reset_n     = '{o: 1'b0, oe: rst_oe_q};
  assign power_off_n     = '{o: 1'b0, oe: pof_oe_q};
  assign low_batt_warn_n = '{o: 1'b0, oe: warn_oe_q};

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  por_length_a: assert property (
    state_q == bsrs_pkg::ST_POR && state_d == bsrs_pkg::ST_RUN |-> cnt_q == POR_LAST)
    else $error("power-on pulse ended at wrong count");

  por_reset_a: assert property (
    state_q == bsrs_pkg::ST_POR |-> rst_oe_q)
    else $error("reset released during power-on pulse");

  por_no_man_a: assert property (
    state_q == bsrs_pkg::ST_POR |=> state_q != bsrs_pkg::ST_DBNC)
    else $error("manual request taken during power-on");

  dead_latch_a: assert property (
    state_q == bsrs_pkg::ST_RUN && !sense_f.dead_above |-> ##2 pof_oe_q && rst_oe_q)
    else $error("dead battery not latched");

  dead_hold_a: assert property (
    state_q == bsrs_pkg::ST_DEAD && sense_f.fresh_above |=> state_q == bsrs_pkg::ST_DEAD)
    else $error("dead latch left without a new power-on");

  man_start_a: assert property (
    state_q == bsrs_pkg::ST_RUN && sense_f.dead_above && sense_f.manual_below
    |=> state_q == bsrs_pkg::ST_DBNC)
    else $error("manual trip not seen");

  man_length_a: assert property (
    state_q == bsrs_pkg::ST_MAN && state_d == bsrs_pkg::ST_HOLD |-> cnt_q == MAN_LAST)
    else $error("manual pulse wrong length");

  dbnc_length_a: assert property (
    state_q == bsrs_pkg::ST_DBNC && state_d == bsrs_pkg::ST_MAN |-> cnt_q == DBNC_LAST)
    else $error("debounce wrong length");

  man_single_a: assert property (
    state_q == bsrs_pkg::ST_HOLD && sense_f.manual_below && sense_f.dead_above
    |-> !rst_oe_q ##1 state_q == bsrs_pkg::ST_HOLD)
    else $error("held switch repeated the pulse");

  warn_follow_a: assert property (
    !sense_f.low_above [*2] |-> warn_oe_q)
    else $error("warning not asserted");

  od_low_a: assert property (
    !sys_reset_n.o && !power_off_n.o && !low_batt_warn_n.o)
    else $error("open-drain pin driven high");

  por_done_c:   cover property (state_q == bsrs_pkg::ST_POR ##1 state_q == bsrs_pkg::ST_RUN);
  man_pulse_c:  cover property (state_q == bsrs_pkg::ST_MAN ##1 state_q == bsrs_pkg::ST_HOLD);
  dead_c:       cover property (state_q == bsrs_pkg::ST_RUN ##1 state_q == bsrs_pkg::ST_DEAD);
  recover_c:    cover property (state_q == bsrs_pkg::ST_DEAD_ARM ##1 state_q == bsrs_pkg::ST_POR);

endmodule : bsrs_supervisor

// file: verilog/bsrs_pkg.sv
package bsrs_pkg;

  // Clock and timing figures
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned POR_TIME_MS    = 700;
  localparam int unsigned POR_CYCLES_DEF = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned MAN_DIV        = 4;
  localparam int unsigned DBNC_DIV       = 32;
  localparam int unsigned GLITCH_TIME_NS = 5000;
  localparam int unsigned GLITCH_CYCLES  = (GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter widths and number of comparator inputs
  localparam int unsigned CNT_W  = 23;
  localparam int unsigned FILT_W = 6;
  localparam int unsigned NSENSE = 4;

  // Reset values
  localparam logic [NSENSE-1:0] SENSE_RST = 4'h0;

  // Comparator results, high when the named condition holds
  typedef struct packed {
    logic fresh_above;   // fresh_batt_or_manual_in above main_threshold_ref
    logic manual_below;  // fresh_batt_or_manual_in below manual_trip_level
    logic dead_above;    // dead_batt_sense above main_threshold_ref
    logic low_above;     // low_batt_sense above warn_threshold_ref
  } bsrs_sense_type;

  // Open-drain pin: output level and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } bsrs_od_pin_type;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_WAIT_POR = 3'h0,
    ST_POR      = 3'h1,
    ST_RUN      = 3'h2,
    ST_DBNC     = 3'h3,
    ST_MAN      = 3'h4,
    ST_HOLD     = 3'h5,
    ST_DEAD     = 3'h6,
    ST_DEAD_ARM = 3'h7
  } bsrs_state_type;

endpackage : bsrs_pkg

// file: test/bsrs_proc_model.sv
`timescale 1ns/1ns
// Processor side: pull-ups on the three pins and a reset pulse meter
module bsrs_proc_model (
  // Clock
  input  wire logic                      core_clk,
  // Supervisor pins
  input  wire bsrs_pkg::bsrs_od_pin_type rst_pin,
  input  wire bsrs_pkg::bsrs_od_pin_type pof_pin,
  input  wire bsrs_pkg::bsrs_od_pin_type warn_pin,
  // Wire levels and last reset pulse
  output logic                           rst_lvl,
  output logic                           pof_lvl,
  output logic                           warn_lvl,
  output int                             pulse_len
);
  int run_q = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Released pins float to the pull-up level, never to a stale value
  assign rst_lvl  = rst_pin.oe ? rst_pin.o : 1'b1;
  assign pof_lvl  = pof_pin.oe ? pof_pin.o : 1'b1;
  assign warn_lvl = warn_pin.oe ? warn_pin.o : 1'b1;
  initial pulse_len = 0;
  // Length of each low reset pulse, stored when the pin returns high
  always @(posedge core_clk) begin
    if (rst_lvl !== 1'b1) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      pulse_len <= run_q;
      run_q     <= 0;
    end
  end
endmodule : bsrs_proc_model

// file: test/bsrs_supervisor_test.sv
`timescale 1ns/1ns
module bsrs_supervisor_test;
  localparam int unsigned PORC = 2560;
  localparam int unsigned LAT  = bsrs_pkg::GLITCH_CYCLES + 2;
  logic                      core_clk  = 1'b0;
  logic                      resetn    = 1'b0;
  bsrs_pkg::bsrs_sense_type  sense_in  = 4'h3;
  bsrs_pkg::bsrs_od_pin_type rst_pin;
  bsrs_pkg::bsrs_od_pin_type pof_pin;
  bsrs_pkg::bsrs_od_pin_type warn_pin;
  logic                      rst_lvl;
  logic                      pof_lvl;
  logic                      warn_lvl;
  int                        pulse_len;
  int                        error_cnt   = 0;
  int                        check_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Short power-on count keeps the run brief; manual is 640, debounce 80
  // Debounce must outlast the glitch filter, else no filtered press is too short
  bsrs_supervisor #(.POR_CYCLES(PORC)) bsrs_supervisor_i (
    .core_clk(core_clk), .resetn(resetn), .sense_in(sense_in),
    .sys_reset_n(rst_pin), .power_off_n(pof_pin), .low_batt_warn_n(warn_pin));
  bsrs_proc_model bsrs_proc_model_i (
    .core_clk(core_clk), .rst_pin(rst_pin), .pof_pin(pof_pin), .warn_pin(warn_pin),
    .rst_lvl(rst_lvl), .pof_lvl(pof_lvl), .warn_lvl(warn_lvl), .pulse_len(pulse_len));
  // 100 ns clock
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_range
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // Bounded wait for the reset wire, then judge it
  task automatic wait_rst(input logic lvl, input int lim);
    int k;
    k = 0;
    while (rst_lvl !== lvl && k < lim) begin
      cyc(1);
      k++;
    end
    check_bit("sys_reset_n", lvl, rst_lvl);
  endtask : wait_rst
  // Flags any dip of reset or power-off over n cycles
  task automatic watch(input int n, output logic moved);
    moved = 1'b0;
    repeat (n) begin
      cyc(1);
      if (rst_lvl !== 1'b1 || pof_lvl !== 1'b1) moved = 1'b1;
    end
  endtask : watch
  ////////////////////////////////////////////////////////////////////////////////
  task automatic power_on();
    sense_in.fresh_above = 1'b1;
    cyc(PORC + LAT);
    check_bit("por hold", 1'b0, rst_lvl);
    wait_rst(1'b1, 4);
    sense_in.fresh_above = 1'b0;
    cyc(100);
    check_bit("fresh ignored", 1'b1, rst_lvl);
  endtask : power_on
  task automatic manual();
    sense_in.manual_below = 1'b1;
    cyc(LAT + PORC / bsrs_pkg::DBNC_DIV);
    check_bit("debounce", 1'b1, rst_lvl);
    wait_rst(1'b0, 4);
    wait_rst(1'b1, PORC / bsrs_pkg::MAN_DIV + 4);
    cyc(2);
    check_range("manual pulse", PORC / 4, PORC / 4 + 1, pulse_len);
    cyc(200);
    check_bit("held switch", 1'b1, rst_lvl);
    sense_in.manual_below = 1'b0;
    cyc(80);
  endtask : manual
  // Closure too short for the filter or the debounce gives no pulse
  task automatic short_press(input int n);
    logic moved;
    sense_in.manual_below = 1'b1;
    cyc(n);
    sense_in.manual_below = 1'b0;
    watch(150, moved);
    check_bit("short press", 1'b0, moved);
  endtask : short_press
  task automatic warning();
    logic moved;
    sense_in.low_above = 1'b0;
    watch(70, moved);
    check_bit("warn on", 1'b0, warn_lvl);
    check_bit("warn isolated", 1'b0, moved);
    sense_in.low_above = 1'b1;
    cyc(70);
    check_bit("warn off", 1'b1, warn_lvl);
  endtask : warning
  task automatic dead();
    logic moved;
    sense_in.dead_above = 1'b0;
    cyc(20);
    sense_in.dead_above = 1'b1;
    watch(100, moved);
    check_bit("dead glitch", 1'b0, moved);
    sense_in.dead_above = 1'b0;
    cyc(70);
    check_bit("power off", 1'b0, pof_lvl);
    check_bit("dead reset", 1'b0, rst_lvl);
    sense_in.dead_above = 1'b1;
    cyc(200);
    check_bit("latched", 1'b0, pof_lvl);
    sense_in.fresh_above = 1'b1;
    cyc(70);
    check_bit("pof released", 1'b1, pof_lvl);
    check_bit("new por", 1'b0, rst_lvl);
    cyc(PORC + LAT - 70);
    check_bit("recovery hold", 1'b0, rst_lvl);
    wait_rst(1'b1, 4);
  endtask : dead
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // Main sequence after an eight-cycle reset
  initial begin
    cyc(8);
    resetn = 1'b1;
    cyc(2);
    check_bit("reset at start", 1'b0, rst_lvl);
    power_on();
    manual();
    short_press(20);
    short_press(55);
    warning();
    dead();
    test_done();
  end
  // Watchdog well past the few thousand cycles the tests need
  initial begin
    cyc(20000);
    error_cnt++;
    test_done();
  end
endmodule : bsrs_supervisor_test
